// file: pkg/spms_defs.svh
`ifndef SPMS_DEFS_SVH
`define SPMS_DEFS_SVH

// register byte addresses on the apb bus
`define SPMS_ADDR_CTRL 12'h000
`define SPMS_ADDR_STAT 12'h004
`define SPMS_ADDR_DATA 12'h008
`define SPMS_ADDR_PINS 12'h00c

// control register field positions
`define SPMS_CTRL_IE 7
`define SPMS_CTRL_EN 6
`define SPMS_CTRL_LSB 5
`define SPMS_CTRL_MASTER_ROLE_SELECT 4
`define SPMS_CTRL_CLOCK_IDLE_POLARITY 3
`define SPMS_CTRL_CLOCK_SAMPLE_PHASE 2
`define SPMS_CTRL_RATE_HI 1
`define SPMS_CTRL_RATE_LO 0

// status register field positions
`define SPMS_STAT_DONE 7
`define SPMS_STAT_WRITE_COLLISION_FLAG 6
`define SPMS_STAT_DBL 0

// pin configuration register field positions
`define SPMS_PINS_MOSI_DIR 0
`define SPMS_PINS_MISO_DIR 1
`define SPMS_PINS_SCK_DIR 2
`define SPMS_PINS_SS_DIR 3
`define SPMS_PINS_SS_LEVEL 4

// reset values
`define SPMS_CTRL_RST 8'h00
`define SPMS_STAT_RST 8'h00
`define SPMS_DATA_RST 8'h00
`define SPMS_PINS_RST 8'h00

// system clock divisors for rate codes 00..11, normal and double speed
`define SPMS_DIV_N0 4
`define SPMS_DIV_N1 16
`define SPMS_DIV_N2 64
`define SPMS_DIV_N3 128
`define SPMS_DIV_D0 2
`define SPMS_DIV_D1 8
`define SPMS_DIV_D2 32
`define SPMS_DIV_D3 64

// serial clock edges in one byte
`define SPMS_EDGES_PER_BYTE 16

`endif

// file: pkg/spms_pkg.sv
package spms_pkg;
  // master clock generator state
  typedef enum logic {
    SPMS_IDLE,
    SPMS_SHIFT
  } spms_state_t;

  // apb address width
  typedef logic [11:0] spms_addr_t;
endpackage

// file: core/spms_port.sv
// Local design decisions: the register offsets and the APB register port.
`include "spms_defs.svh"

// Summary of operation
// - slave selected: active, data out as configured
// - slave deselected: all inputs, no reception
// - deselect resets bit counter, drops partial bits
// - master, select output: plain general output
// - master, select input low: become slave
// - forced slave role also sets done flag
// - control bit 7 enables interrupt request
// - control bit 6 enables all serial operation
// - control bit 5 chooses lsb first
// - control bit 4 chooses master role
// - control bit 3 sets clock idle level
// - control bit 2 sets sample edge
// - four modes, shift and sample opposite edges
// - rate bits divide by 4,16,64,128
// - double speed halves divisors to 2,8,32,64
// - status bit 7 set at byte end
// - done flag cleared by ack or read sequence
// - status bit 6 set on busy data write
// - collision clear sequence also clears done flag
// - status bits 5..1 read as zero
// - data write starts, read returns receive buffer
// - master shifts eight bits then stops clock
// - single transmit buffer, double receive buffer
// - slave output quiet until selected
module spms_port (
  input wire logic i_clk,
  input wire logic i_rst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire spms_pkg::spms_addr_t i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // processor side
  input wire logic i_global_irq_en,
  input wire logic i_irq_ack,
  output logic o_irq,
  // serial clock pin
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe_n,
  // master out, slave in pin
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe_n,
  // master in, slave out pin
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe_n,
  // slave select pin, active low
  input wire logic i_ss_n,
  output logic o_ss_n,
  output logic o_ss_n_oe_n
);
  import spms_pkg::*;

  // software registers and internal state
  logic [7:0] ctrl_q; // control register
  logic done_q; // transfer done flag
  logic write_collision_flag_q; // write collision flag
  logic dbl_q; // double speed bit
  logic [4:0] pins_q; // pin direction and select level
  logic [7:0] rx_buf_q; // receive buffer
  logic [7:0] sr_q; // shift register
  logic samp_q; // last sampled serial bit
  logic [3:0] edge_cnt_q; // serial clock edge count in byte
  logic [6:0] div_cnt_q; // system clocks in current half period
  logic sck_q; // generated serial clock level
  logic sck_prev_q; // registered slave clock input
  logic ss_prev_q; // registered slave select input
  logic arm_done_q; // status read saw done flag
  logic arm_write_collision_flag_q; // status read saw collision flag
  spms_state_t state_q; // master clock generator state

  // decoded fields
  logic en, master, lsb_first, clock_idle_polarity, clock_sample_phase;
  logic [1:0] rate;
  assign en = ctrl_q[`SPMS_CTRL_EN];
  assign master = ctrl_q[`SPMS_CTRL_MASTER_ROLE_SELECT];
  assign lsb_first = ctrl_q[`SPMS_CTRL_LSB];
  assign clock_idle_polarity = ctrl_q[`SPMS_CTRL_CLOCK_IDLE_POLARITY];
  assign clock_sample_phase = ctrl_q[`SPMS_CTRL_CLOCK_SAMPLE_PHASE];
  assign rate = ctrl_q[`SPMS_CTRL_RATE_HI:`SPMS_CTRL_RATE_LO];

  // apb access strobes, taken in the access phase
  logic acc, wr, rd;
  logic hit_ctrl, hit_stat, hit_data, hit_pins;
  assign acc = i_psel & i_penable;
  assign wr = acc & i_pwrite;
  assign rd = acc & ~i_pwrite;
  assign hit_ctrl = (i_paddr == `SPMS_ADDR_CTRL);
  assign hit_stat = (i_paddr == `SPMS_ADDR_STAT);
  assign hit_data = (i_paddr == `SPMS_ADDR_DATA);
  assign hit_pins = (i_paddr == `SPMS_ADDR_PINS);

  // slave answers in the first access cycle
  assign o_pready = 1'b1;
  assign o_pslverr = acc & ~(hit_ctrl | hit_stat | hit_data | hit_pins);

  // mode fault: select pulled low while master with select as input
  logic mode_fault;
  assign mode_fault = en & master & ~pins_q[`SPMS_PINS_SS_DIR] &
                      ~i_ss_n;

  // slave is selected only when enabled, slave role and select low
  logic slave_sel;
  assign slave_sel = en & ~master & ~ss_prev_q;

  // half period of the master clock in system clocks
  logic [6:0] half;
  always_comb begin
    half = 7'h01;
    unique case ({dbl_q, rate})
      3'b000: half = 7'(`SPMS_DIV_N0 / 2);
      3'b001: half = 7'(`SPMS_DIV_N1 / 2);
      3'b010: half = 7'(`SPMS_DIV_N2 / 2);
      3'b011: half = 7'(`SPMS_DIV_N3 / 2);
      3'b100: half = 7'(`SPMS_DIV_D0 / 2);
      3'b101: half = 7'(`SPMS_DIV_D1 / 2);
      3'b110: half = 7'(`SPMS_DIV_D2 / 2);
      3'b111: half = 7'(`SPMS_DIV_D3 / 2);
    endcase
  end

  // serial clock edge events from either role
  logic m_edge, s_rise, s_fall, s_edge, edge_ev, lead;
  assign m_edge = (state_q == SPMS_SHIFT) & (div_cnt_q == half - 7'h01);
  assign s_rise = ~sck_prev_q & i_sck;
  assign s_fall = sck_prev_q & ~i_sck;
  assign s_edge = slave_sel & ~i_ss_n & (s_rise | s_fall);
  assign edge_ev = master ? m_edge : s_edge;
  // leading edge leaves the idle level
  assign lead = master ? ~edge_cnt_q[0] : (clock_idle_polarity ? s_fall : s_rise);

  // sample edge is leading when phase is zero, trailing otherwise
  logic samp_ev, setup_ev, last_ev, in_bit;
  assign samp_ev = edge_ev & (lead ^ clock_sample_phase);
  assign setup_ev = edge_ev & ~(lead ^ clock_sample_phase);
  assign last_ev = edge_ev &
                   (edge_cnt_q == 4'(`SPMS_EDGES_PER_BYTE - 1));
  assign in_bit = master ? i_miso : i_mosi;

  // shift one bit in at the end away from the output
  function automatic logic [7:0] shift_in(input logic [7:0] v,
                                          input logic b,
                                          input logic lsb);
    shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // byte finished this cycle
  logic [7:0] done_byte;
  assign done_byte = shift_in(sr_q, clock_sample_phase ? in_bit : samp_q, lsb_first);

  // busy: master clock running or slave part way through a byte
  logic busy;
  assign busy = (state_q == SPMS_SHIFT) | (~master & edge_cnt_q != 4'h0);

  // data register access and its collision check
  logic data_wr, data_acc;
  assign data_wr = wr & hit_data;
  assign data_acc = acc & hit_data;

  // control register; mode fault drops master role
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_q <= `SPMS_CTRL_RST;
    end else if (mode_fault) begin
      ctrl_q[`SPMS_CTRL_MASTER_ROLE_SELECT] <= 1'b0;
    end else if (wr & hit_ctrl) begin
      ctrl_q <= i_pwdata[7:0];
    end
  end

  // pin direction and general select level
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pins_q <= 5'(`SPMS_PINS_RST);
    end else if (wr & hit_pins) begin
      pins_q <= i_pwdata[4:0];
    end
  end

  // double speed bit, the only writable status bit
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dbl_q <= 1'(`SPMS_STAT_RST);
    end else if (wr & hit_stat) begin
      dbl_q <= i_pwdata[`SPMS_STAT_DBL];
    end
  end

  // clear sequence: status read with flag set arms the data access
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      arm_done_q <= 1'b0;
      arm_write_collision_flag_q <= 1'b0;
    end else if (rd & hit_stat) begin
      arm_done_q <= done_q;
      arm_write_collision_flag_q <= write_collision_flag_q;
    end else if (data_acc) begin
      arm_done_q <= 1'b0;
      arm_write_collision_flag_q <= 1'b0;
    end
  end

  // done flag; a new set wins over any clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      done_q <= 1'b0;
    end else if (last_ev | mode_fault) begin
      done_q <= 1'b1;
    end else if (i_irq_ack |
                 (data_acc & (arm_done_q | arm_write_collision_flag_q))) begin
      done_q <= 1'b0;
    end
  end

  // collision flag; set wins over the clear sequence
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      write_collision_flag_q <= 1'b0;
    end else if (data_wr & busy) begin
      write_collision_flag_q <= 1'b1;
    end else if (data_acc & arm_write_collision_flag_q) begin
      write_collision_flag_q <= 1'b0;
    end
  end

  // receive buffer holds last complete byte until the next one
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_buf_q <= `SPMS_DATA_RST;
    end else if (last_ev) begin
      rx_buf_q <= done_byte;
    end
  end

  // shift register: loaded by idle data write, shifted on setup edges
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sr_q <= `SPMS_DATA_RST;
    end else if (data_wr & ~busy) begin
      sr_q <= i_pwdata[7:0];
    end else if (last_ev & ~clock_sample_phase) begin
      // phase one ends on a sample edge: data out must not move there
      sr_q <= done_byte;
    end else if (setup_ev & (edge_cnt_q != 4'h0)) begin
      sr_q <= shift_in(sr_q, samp_q, lsb_first);
    end
  end

  // sampled bit, cleared when the slave is deselected
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      samp_q <= 1'b0;
    end else if (~master & i_ss_n) begin
      samp_q <= 1'b0;
    end else if (samp_ev) begin
      samp_q <= in_bit;
    end
  end

  // edge counter; reset by deselect, mode fault or disable
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      edge_cnt_q <= 4'h0;
    end else if (~en | mode_fault | (~master & i_ss_n)) begin
      edge_cnt_q <= 4'h0;
    end else if (edge_ev) begin
      edge_cnt_q <= edge_cnt_q + 4'h1;
    end
  end

  // master clock generator state
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= SPMS_IDLE;
    end else begin
      unique case (state_q)
        SPMS_IDLE: begin
          if (data_wr & en & master & ~mode_fault) begin
            state_q <= SPMS_SHIFT;
          end
        end
        SPMS_SHIFT: begin
          if (~en | ~master | mode_fault | last_ev) begin
            state_q <= SPMS_IDLE;
          end
        end
      endcase
    end
  end

  // divider counts system clocks within each half period
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      div_cnt_q <= 7'h00;
    end else if (state_q != SPMS_SHIFT | m_edge) begin
      div_cnt_q <= 7'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 7'h01;
    end
  end

  // generated clock toggles per edge and rests at idle level
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sck_q <= 1'b0;
    end else if (state_q != SPMS_SHIFT) begin
      sck_q <= clock_idle_polarity;
    end else if (m_edge) begin
      sck_q <= ~sck_q;
    end
  end

  // slave clock and select registered for edge detection
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sck_prev_q <= 1'b0;
      ss_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= i_sck;
      ss_prev_q <= i_ss_n;
    end
  end

  // read data captured in the setup phase
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel & ~i_penable & ~i_pwrite) begin
      if (hit_ctrl) begin
        o_prdata <= {24'h00_0000, ctrl_q};
      end else if (hit_stat) begin
        o_prdata <= {24'h00_0000, done_q, write_collision_flag_q, 5'h00, dbl_q};
      end else if (hit_data) begin
        o_prdata <= {24'h00_0000, rx_buf_q};
      end else if (hit_pins) begin
        o_prdata <= {27'h000_0000, pins_q};
      end else begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end

  // interrupt request
  assign o_irq = ctrl_q[`SPMS_CTRL_IE] & done_q & i_global_irq_en;

  // outgoing serial bit
  logic out_bit;
  assign out_bit = lsb_first ? sr_q[0] : sr_q[7];

  // pin drivers; enable low means driving
  assign o_sck = sck_q;
  assign o_sck_oe_n = ~(en & master & pins_q[`SPMS_PINS_SCK_DIR]);
  assign o_mosi = out_bit;
  assign o_mosi_oe_n = ~(en & master &
                         pins_q[`SPMS_PINS_MOSI_DIR]);
  assign o_miso = out_bit;
  assign o_miso_oe_n = ~(slave_sel & ~i_ss_n &
                         pins_q[`SPMS_PINS_MISO_DIR]);
  // select pin as general output in master role
  assign o_ss_n = pins_q[`SPMS_PINS_SS_LEVEL];
  assign o_ss_n_oe_n = ~(master & pins_q[`SPMS_PINS_SS_DIR]);
endmodule

// file: sim/spms_port_chk.sv
`include "spms_defs.svh"
module spms_port_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire spms_pkg::spms_addr_t i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic i_global_irq_en,
  input wire logic o_irq,
  input wire logic o_sck,
  input wire logic o_sck_oe_n,
  input wire logic o_mosi_oe_n,
  input wire logic o_miso_oe_n,
  input wire logic i_ss_n,
  input wire logic o_ss_n_oe_n
);
  import spms_pkg::*;
  logic [7:0] ctrl_q; // last written control value
  logic [4:0] edges_q; // driven clock edges in this byte
  logic busy_q; // a byte has been started
  wire wr = i_psel & i_penable & i_pwrite;
  wire wr_ctrl = wr && i_paddr == `SPMS_ADDR_CTRL;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // mirror of control writes
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) ctrl_q <= 8'h00;
    else if (wr_ctrl) ctrl_q <= i_pwdata[7:0];
  end
  // edge count from the data write that starts a byte
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || wr_ctrl) begin
      busy_q <= 1'b0;
      edges_q <= 5'h00;
    end else if (wr && i_paddr == `SPMS_ADDR_DATA && !busy_q) begin
      busy_q <= 1'b1;
      edges_q <= 5'h00;
    end else if (edges_q == 5'h10) begin
      busy_q <= 1'b0;
    end else if (busy_q && !o_sck_oe_n && o_sck != $past(o_sck)) begin
      edges_q <= edges_q + 5'h01;
    end
  end
  a_irq_enables:
    assert property (o_irq |-> i_global_irq_en && ctrl_q[7])
    else $error("interrupt without its enables");
  a_status_zeros:
    assert property (i_psel && i_penable && !i_pwrite &&
      i_paddr == `SPMS_ADDR_STAT |-> o_prdata[31:8] == 24'h0 &&
      o_prdata[5:1] == 5'h0)
    else $error("status reserved bits not zero");
  a_miso_selected:
    assert property (!o_miso_oe_n |-> !i_ss_n)
    else $error("data out driven while deselected");
  a_forced_slave:
    assert property (ctrl_q[6] && !o_sck_oe_n && o_ss_n_oe_n && !i_ss_n
      |-> ##[1:4] (o_sck_oe_n && o_mosi_oe_n && o_irq))
    else $error("master not dropped to slave");
  a_byte_edges:
    assert property ($rose(o_irq) && !o_sck_oe_n |=> edges_q == 5'h10)
    else $error("byte did not take sixteen clock edges");
  a_idle_level:
    assert property ($rose(o_irq) && !o_sck_oe_n |-> o_sck == ctrl_q[3])
    else $error("clock not at idle level after byte");
  a_off_quiet:
    assert property ((!ctrl_q[6] && $stable(ctrl_q)) [*3]
      |=> $stable(o_sck))
    else $error("clock moved while port disabled");
  a_select_plain:
    assert property (!o_ss_n_oe_n && !o_sck_oe_n && !wr |=> !o_sck_oe_n)
    else $error("select output changed the role");
endmodule

bind spms_port spms_port_chk i_chk (.i_clk, .i_rst_n, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
  .i_global_irq_en, .o_irq, .o_sck, .o_sck_oe_n, .o_mosi_oe_n,
  .o_miso_oe_n, .i_ss_n, .o_ss_n_oe_n);

// file: sim/spms_peer.sv
module spms_peer (
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_ss_n,
  input wire logic i_clock_sample_phase,
  input wire logic i_lsb,
  input wire logic [7:0] i_tx,
  output logic o_miso,
  output logic [7:0] o_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sr, rx; // shift and receive registers
  logic p, f; // edge parity, bit sampled since last shift
  int n; // bits taken in this byte
  // selection restarts the byte
  always @(negedge i_ss_n) begin
    sr = i_tx;
    p = 0;
    f = 0;
    n = 0;
  end
  // sample on one edge, shift on the other
  always @(i_sck) begin
    if (i_ss_n === 1'b0) begin
      p = ~p;
      if (p ^ i_clock_sample_phase) begin
        rx = i_lsb ? {i_mosi, rx[7:1]} : {rx[6:0], i_mosi};
        f = 1;
        n++;
        if (n == 8) o_rx = rx;
      end else if (f) begin
        sr = n == 8 ? i_tx : i_lsb ? sr >> 1 : sr << 1;
        n = n % 8;
        f = 0;
      end
    end
  end
  // a released line shows the inverse of its last bit
  assign o_miso = (i_lsb ? sr[0] : sr[7]) ^ (i_ss_n !== 1'b0);
endmodule

// file: sim/spi_master_slave_port_tb.sv
`include "spms_defs.svh"
module spi_master_slave_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spms_pkg::*;
  logic i_clk, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic i_global_irq_en = 1, i_irq_ack = 0, tb_sck = 0, tb_mosi = 0;
  logic tb_ss = 1, o_pready, o_pslverr, o_irq, o_sck, o_sck_oe_n, o_mosi;
  logic o_mosi_oe_n, o_miso, o_miso_oe_n, o_ss_n, o_ss_n_oe_n, err;
  logic peer_miso;
  spms_addr_t i_paddr = 0;
  logic [31:0] i_pwdata = 0, o_prdata, rd, r;
  logic [7:0] ctrl = 0, tx, peer_tx = 0, peer_rx, got;
  int miscompares = 0, checks_done = 0, seed = 74, div, n;
  int divs[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
  // pin levels: the driving side wins
  wire sck_w = o_sck_oe_n ? tb_sck : o_sck;
  wire mosi_w = o_mosi_oe_n ? tb_mosi : o_mosi;
  wire miso_w = o_miso_oe_n ? peer_miso : o_miso;
  wire ss_w = o_ss_n_oe_n ? tb_ss : o_ss_n;
  spms_port i_dut (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_global_irq_en, .i_irq_ack, .o_irq, .i_sck(sck_w), .o_sck,
    .o_sck_oe_n, .i_mosi(mosi_w), .o_mosi, .o_mosi_oe_n,
    .i_miso(miso_w), .o_miso, .o_miso_oe_n, .i_ss_n(ss_w), .o_ss_n,
    .o_ss_n_oe_n);
  spms_peer i_peer (.i_sck(sck_w), .i_mosi(mosi_w), .i_ss_n(ss_w),
    .i_clock_sample_phase(ctrl[2]), .i_lsb(ctrl[5]), .i_tx(peer_tx),
    .o_miso(peer_miso), .o_rx(peer_rx));
  // system clock
  initial begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  // one apb transfer, held until ready
  task automatic apb(input logic w, input spms_addr_t a,
                     input logic [7:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= {24'h0, d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  // count cycles until the interrupt shows
  task automatic wait_irq();
    n = 0;
    while (o_irq !== 1'b1 && n < 3000) begin
      @(negedge i_clk);
      n++;
    end
    @(posedge i_clk);
  endtask
  // external master, mode 0, msb first, slow clock
  task automatic sbyte(input logic [7:0] b, input int nb);
    tb_ss <= 1'b0;
    repeat (4) @(posedge i_clk);
    for (int k = 7; k > 7 - nb; k--) begin
      tb_mosi <= b[k];
      repeat (4) @(posedge i_clk);
      got[k] = o_miso;
      tb_sck <= 1'b1;
      repeat (4) @(posedge i_clk);
      tb_sck <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
    tb_ss <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #600000;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    // reset values and an unmapped word
    for (int a = 0; a < 5; a++) begin
      apb(0, spms_addr_t'(a * 4), 0);
      chk(rd, 0);
      chk(err, a == 4);
    end
    $display("test reset done");
    // master bytes over all modes and orders, at random rates
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      tx = r[15:8];
      peer_tx = r[23:16];
      ctrl = {2'b11, i[2], 1'b1, i[1:0], r[1:0]};
      div = divs[r[2:0]];
      apb(1, `SPMS_ADDR_PINS, 8'h1d);
      apb(1, `SPMS_ADDR_STAT, {7'h0, r[2]});
      apb(1, `SPMS_ADDR_CTRL, ctrl);
      apb(1, `SPMS_ADDR_PINS, 8'h0d);
      apb(1, `SPMS_ADDR_DATA, tx);
      if (i == 0) apb(1, `SPMS_ADDR_DATA, ~tx);
      wait_irq();
      n += i == 0 ? 3 : 0;
      chk(n >= 8 * div - 1 && n <= 8 * div + 2, 1);
      chk(peer_rx, tx);
      if (i[0]) begin
        i_irq_ack <= 1'b1;
        @(posedge i_clk);
        i_irq_ack <= 1'b0;
        @(posedge i_clk);
        chk(o_irq, 0);
      end
      apb(0, `SPMS_ADDR_STAT, 0);
      chk(rd, {24'h0, ~i[0], i == 0, 5'h0, r[2]});
      apb(0, `SPMS_ADDR_DATA, 0);
      chk(rd, peer_tx);
      apb(0, `SPMS_ADDR_STAT, 0);
      chk(rd, {31'h0, r[2]});
    end
    $display("test master done");
    // disabled port ignores a data write
    apb(1, `SPMS_ADDR_CTRL, 8'h90);
    apb(1, `SPMS_ADDR_DATA, 8'h5a);
    repeat (40) @(posedge i_clk);
    apb(0, `SPMS_ADDR_STAT, 0);
    chk(rd[7], 0);
    // select input low drops the master role
    apb(1, `SPMS_ADDR_PINS, 8'h05);
    apb(1, `SPMS_ADDR_CTRL, 8'hd0);
    tb_ss <= 1'b0;
    repeat (6) @(posedge i_clk);
    chk(o_irq, 1);
    apb(0, `SPMS_ADDR_CTRL, 0);
    chk(rd, 32'hc0);
    tb_ss <= 1'b1;
    apb(1, `SPMS_ADDR_CTRL, 8'hd0);
    apb(0, `SPMS_ADDR_CTRL, 0);
    chk(rd, 32'hd0);
    apb(0, `SPMS_ADDR_STAT, 0);
    apb(0, `SPMS_ADDR_DATA, 0);
    $display("test role drop done");
    // slave bytes with a cut-short byte between them
    ctrl = 8'hc0;
    apb(1, `SPMS_ADDR_CTRL, ctrl);
    apb(1, `SPMS_ADDR_PINS, 8'h02);
    apb(1, `SPMS_ADDR_DATA, 8'h3c);
    chk(o_miso_oe_n, 1);
    for (int j = 0; j < 3; j++) begin
      r = $random(seed);
      sbyte(r[7:0], j == 1 ? 3 : 8);
      chk(o_irq, j != 1);
      if (j == 0) chk(got, 8'h3c);
      apb(0, `SPMS_ADDR_STAT, 0);
      apb(0, `SPMS_ADDR_DATA, 0);
      if (j == 2) chk(rd, r[7:0]);
    end
    $display("test slave done");
    finish_test();
  end
endmodule
